// file: rtl/hrs_regs.svh
`ifndef HRS_REGS_SVH
`define HRS_REGS_SVH

// card interface mode codes on mode_sel
`define HRS_MODE_MEM 2'h0
`define HRS_MODE_IO 2'h1
`define HRS_MODE_IDE 2'h2
// data bus width during any transfer
`define HRS_WORD_W 16
// depth of the data-out staging fifo
`define HRS_FIFO_DEPTH 8
// reset value of the data bus register
`define HRS_DATA_RST 16'h0000

`endif

// file: rtl/hrs_pkg.sv
package hrs_pkg;

   // port phase: what the data bus is doing
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_PIO,
      PH_DIN,
      PH_DOUT
   } hrs_phase_t;

   // all state of the port
   typedef struct packed {
      hrs_phase_t phase;
      logic hs_q;
      logic dmarq_q;
      logic [15:0] dd_out_q;
      logic dd_oe_q;
      logic dstrobe_q;
      logic overrun_q;
   } hrs_state_t;

endpackage : hrs_pkg

// file: rtl/hrs_fifo.sv
module hrs_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   localparam int AW = $clog2(D);

   // storage, pointers and registered read word
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic ov_q;
      logic [W-1:0] od_q;
   } hrs_fifo_st_t;

   hrs_fifo_st_t s_q, s_d;
   logic push; // word accepted
   logic load; // memory word moved to output register

   // pointer wrap helper
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(D - 1)) ? '0 : p + AW'(1);
   endfunction : bump

   ///////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d = s_q;
      in_ready = (s_q.count < (AW + 1)'(D)); // full only when memory full
      push = in_valid && in_ready;
      load = (s_q.count != '0) && (!s_q.ov_q || out_ready);
      if (push) begin
         s_d.mem[s_q.wptr] = in_data;
         s_d.wptr = bump(s_q.wptr);
      end
      // output register drains or refills
      if (load) begin
         s_d.od_q = s_q.mem[s_q.rptr];
         s_d.rptr = bump(s_q.rptr);
         s_d.ov_q = 1'b1;
      end else if (out_ready) begin
         s_d.ov_q = 1'b0;
      end
      s_d.count = s_q.count + (AW + 1)'(push) - (AW + 1)'(load);
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign out_valid = s_q.ov_q;
   assign out_data = s_q.od_q;

endmodule : hrs_fifo

// file: rtl/hrs_port.sv
`include "hrs_regs.svh"

// Function
// RQ1 - memory mode ignores read strobe completely
// RQ2 - I/O mode read strobe drives read data
// RQ3 - IDE without Ultra DMA: same strobe
// RQ4 - host asserts ready to accept data-in
// RQ5 - latch word on both strobe edges
// RQ6 - strobe pause latches nothing
// RQ7 - ready negated: no new data words
// RQ8 - request held until acknowledge, then reasserted
// RQ9 - host keeps selects negated, 16-bit transfers
module hrs_port (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [1:0] mode_sel,
   input wire logic io_if_en,
   input wire logic udma_rd_en,
   input wire logic udma_wr_en,
   input wire logic iord_n,
   input wire logic hdmardy_n,
   input wire logic hstrobe,
   input wire logic dmack_n,
   input wire logic [15:0] dd_in,
   output logic [15:0] dd_out,
   output logic dd_oe,
   output logic dstrobe,
   output logic dmarq,
   output logic overrun,
   input wire logic [15:0] io_rdata,
   input wire logic src_valid,
   output logic src_ready,
   input wire logic [15:0] src_data,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [15:0] wr_data
);

   hrs_pkg::hrs_state_t s_q, s_d; // whole port state
   logic udma_on; // an Ultra DMA command is active
   logic pio_rd; // legal I/O read strobe this cycle
   logic acked; // host acknowledges DMA
   logic hs_edge; // either edge of the host strobe
   logic push; // data-out word offered to fifo
   logic push_ready; // fifo has room
   logic want; // data side ready to transfer

   ///////////////////////////////////////////////////////////////////////////
   // data-out staging fifo
   hrs_fifo #(
      .W(`HRS_WORD_W),
      .D(`HRS_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .srst(srst),
      .in_valid(push),
      .in_ready(push_ready),
      .in_data(dd_in),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(wr_data)
   );

   ///////////////////////////////////////////////////////////////////////////
   // combinational decode
   always_comb begin
      udma_on = (mode_sel == `HRS_MODE_IDE) && (udma_rd_en || udma_wr_en);
      acked = !dmack_n;
      // memory mode never qualifies the strobe
      pio_rd = !iord_n && (((mode_sel == `HRS_MODE_IO) && io_if_en) // RQ1 RQ2
         || ((mode_sel == `HRS_MODE_IDE) && !udma_on)); // RQ3
      // any level change of the host strobe is one word
      hs_edge = (hstrobe != s_q.hs_q); // RQ5 RQ6
      push = udma_on && udma_wr_en && acked && hs_edge; // RQ5 RQ9
      // data-in words move only while the host is ready
      src_ready = udma_on && udma_rd_en && !udma_wr_en && acked && !hdmardy_n; // RQ4 RQ7
      // room for a word out, or a word waiting to go in
      want = udma_on && (udma_wr_en ? push_ready : src_valid);
   end

   ///////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d = s_q;
      s_d.hs_q = hstrobe;
      s_d.dd_oe_q = 1'b0;
      // request stays up until acknowledged, rises again if more data
      s_d.dmarq_q = want || (s_q.dmarq_q && dmack_n); // RQ8
      if (push && !push_ready) begin
         // host ignored back-pressure: word lost, sticky
         s_d.overrun_q = 1'b1;
      end
      unique case (s_q.phase)
         hrs_pkg::PH_IDLE: begin
            if (pio_rd) begin
               s_d.phase = hrs_pkg::PH_PIO;
            end else if (udma_on && acked) begin
               s_d.phase = udma_wr_en ? hrs_pkg::PH_DOUT : hrs_pkg::PH_DIN;
            end
         end
         hrs_pkg::PH_PIO: begin
            if (!pio_rd) begin
               s_d.phase = hrs_pkg::PH_IDLE;
            end
         end
         hrs_pkg::PH_DIN, hrs_pkg::PH_DOUT: begin
            if (!udma_on || !acked) begin
               s_d.phase = hrs_pkg::PH_IDLE;
            end
         end
      endcase
      // read data on the bus while the strobe is asserted
      if (pio_rd) begin
         s_d.dd_out_q = io_rdata; // RQ2 RQ3
         s_d.dd_oe_q = 1'b1;
      end else if (udma_on && udma_rd_en && !udma_wr_en && acked) begin
         s_d.dd_oe_q = 1'b1;
         // new word only on a handshake, else hold
         if (src_ready && src_valid) begin
            s_d.dd_out_q = src_data; // RQ7
            s_d.dstrobe_q = !s_q.dstrobe_q;
         end
      end
      // clear the overrun flag whenever no Ultra DMA command is active
      if (!udma_on) begin
         s_d.overrun_q = 1'b0;
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_q.phase <= hrs_pkg::PH_IDLE;
         s_q.hs_q <= 1'b0;
         s_q.dmarq_q <= 1'b0;
         s_q.dd_out_q <= `HRS_DATA_RST;
         s_q.dd_oe_q <= 1'b0;
         s_q.dstrobe_q <= 1'b0;
         s_q.overrun_q <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dd_out = s_q.dd_out_q;
   assign dd_oe = s_q.dd_oe_q;
   assign dstrobe = s_q.dstrobe_q;
   assign dmarq = s_q.dmarq_q;
   assign overrun = s_q.overrun_q;

   ///////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   // memory mode: bus never driven whatever the strobe does
   a_mem_mode_quiet: assert property ( // RQ1
      (mode_sel == `HRS_MODE_MEM) [*2] |-> !dd_oe
   ) else $error("bus driven in memory mode");

   // I/O read strobe puts read data on the bus next cycle
   a_io_read_data: assert property ( // RQ2
      (mode_sel == `HRS_MODE_IO) && io_if_en && !iord_n
      |=> dd_oe && (dd_out == $past(io_rdata))
   ) else $error("I/O read data not presented");

   // IDE without Ultra DMA answers the strobe the same way
   a_ide_pio_read: assert property ( // RQ3
      (mode_sel == `HRS_MODE_IDE) && !udma_rd_en && !udma_wr_en && !iord_n
      |=> dd_oe && (dd_out == $past(io_rdata))
   ) else $error("IDE strobe read not presented");

   // data-in taken only with host ready
   a_din_needs_ready: assert property ( // RQ4
      src_ready |-> !hdmardy_n && !dmack_n
   ) else $error("data-in taken without host ready");

   // every strobe edge in a write burst offers one word
   a_edge_latches: assert property ( // RQ5
      (mode_sel == `HRS_MODE_IDE) && udma_wr_en && !dmack_n && (hstrobe != $past(hstrobe))
      |-> push
   ) else $error("strobe edge not latched");

   // no strobe edge, no word
   a_pause_no_latch: assert property ( // RQ6
      $stable(hstrobe) |-> !push
   ) else $error("word latched without strobe edge");

   // host not ready: presented word and strobe stay
   a_din_paused: assert property ( // RQ7
      (mode_sel == `HRS_MODE_IDE) && udma_rd_en && !dmack_n && hdmardy_n && !pio_rd
      |=> $stable(dd_out) && $stable(dstrobe)
   ) else $error("new data-in word while host paused");

   // request not dropped before acknowledge
   a_dmarq_held: assert property ( // RQ8
      dmarq && dmack_n |=> dmarq
   ) else $error("request dropped before acknowledge");

   // each data-in handshake flips the device strobe once
   a_dstrobe_step: assert property ( // RQ7
      src_ready && src_valid |=> (dstrobe != $past(dstrobe))
   ) else $error("data-in strobe did not toggle");

   // write burst: device never drives the data bus
   a_wr_no_drive: assert property ( // RQ5
      (mode_sel == `HRS_MODE_IDE) && udma_wr_en |=> !dd_oe
   ) else $error("bus driven during data-out");

   // lost-word flag stays up for the rest of the command
   a_overrun_sticky: assert property ( // RQ5
      overrun && (mode_sel == `HRS_MODE_IDE) && (udma_rd_en || udma_wr_en) |=> overrun
   ) else $error("overrun cleared inside a command");

   c_io_read: cover property (pio_rd ##1 dd_oe);
   c_write_burst: cover property (push [*3]);
   c_read_burst: cover property ((src_ready && src_valid) ##1 hdmardy_n ##1 src_ready);
   c_fifo_full: cover property (udma_wr_en && !push_ready);
   c_dout_phase: cover property ((s_q.phase == hrs_pkg::PH_DOUT) && push);

endmodule : hrs_port

// file: tb/hrs_host.sv
// host side of the port: pio strobe, dma acknowledge, data-out strobe
module hrs_host (
   input wire logic ref_clk,
   output logic iord_n,
   output logic hdmardy_n,
   output logic hstrobe,
   output logic dmack_n,
   output logic [15:0] dd_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle host: strobes negated, no acknowledge
   initial begin
      iord_n = 1'b1;
      hdmardy_n = 1'b1;
      hstrobe = 1'b0;
      dmack_n = 1'b1;
      dd_in = 16'h0000;
   end
   // hold the read strobe low for n cycles
   task automatic pio(input int n);
      iord_n = 1'b0;
      repeat (n) @(posedge ref_clk);
      #2 iord_n = 1'b1;
   endtask : pio
   // acknowledge and ready levels, active high arguments
   task automatic ack(input logic a, input logic r);
      dmack_n = !a;
      hdmardy_n = !r;
   endtask : ack
   // one strobe edge carries one full word
   task automatic toggle(input logic [15:0] w);
      hstrobe = ~hstrobe;
      dd_in = w;
      @(posedge ref_clk);
      #2;
   endtask : toggle
   // no edges; data lines change every cycle so no stale word looks valid
   task automatic pause(input int n);
      repeat (n) begin
         dd_in = ~dd_in;
         @(posedge ref_clk);
         #2;
      end
   endtask : pause
endmodule : hrs_host

// file: tb/host_read_and_udma_strobes_tb.sv
module host_read_and_udma_strobes_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic srst;
   logic [1:0] mode_sel;
   logic io_if_en, udma_rd_en, udma_wr_en;
   logic iord_n, hdmardy_n, hstrobe, dmack_n, dd_oe, dstrobe, dmarq, overrun;
   logic src_valid, src_ready, wr_valid, wr_ready, old_strobe;
   logic [15:0] dd_in, dd_out, wr_data, io_rdata, src_data;
   logic [15:0] got_q[$]; // words leaving the data-out sink
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;
   always #10 ref_clk = ~ref_clk;
   hrs_port uut (.ref_clk(ref_clk), .srst(srst), .mode_sel(mode_sel), .io_if_en(io_if_en),
      .udma_rd_en(udma_rd_en), .udma_wr_en(udma_wr_en), .iord_n(iord_n),
      .hdmardy_n(hdmardy_n), .hstrobe(hstrobe), .dmack_n(dmack_n), .dd_in(dd_in),
      .dd_out(dd_out), .dd_oe(dd_oe), .dstrobe(dstrobe), .dmarq(dmarq), .overrun(overrun),
      .io_rdata(io_rdata), .src_valid(src_valid), .src_ready(src_ready),
      .src_data(src_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data));
   hrs_host host (.ref_clk(ref_clk), .iord_n(iord_n), .hdmardy_n(hdmardy_n),
      .hstrobe(hstrobe), .dmack_n(dmack_n), .dd_in(dd_in));
   ////////////////////////////////////////////////////////////////////////////
   // sink monitor and hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (wr_valid === 1'b1 && wr_ready === 1'b1) got_q.push_back(wr_data);
      if (cycles == 3000) begin // far beyond the roughly 60 cycles needed
         n_mismatch++;
         conclude();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : cyc
   ////////////////////////////////////////////////////////////////////////////
   // pio read in every mode: memory, unconfigured i/o and code 3 ignore it
   task automatic t_pio();
      logic [1:0] md[5] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h3};
      logic en[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      logic ex[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 5; i++) begin
         mode_sel = md[i];
         io_if_en = en[i];
         io_rdata = 16'hA000 + 16'(i);
         host.pio(1);
         chk(16'(dd_oe), 16'(ex[i]), "pio enable");
         if (ex[i]) chk(dd_out, 16'hA000 + 16'(i), "pio data");
         cyc(1);
         chk(16'(dd_oe), 16'h0000, "pio release");
      end
   endtask : t_pio
   // data-out on both edges with pauses between
   task automatic t_wr();
      mode_sel = 2'h2;
      udma_wr_en = 1'b1;
      wr_ready = 1'b1;
      host.ack(1'b1, 1'b0);
      got_q.delete();
      host.toggle(16'h1111);
      host.toggle(16'h2222);
      host.pause(3);
      host.toggle(16'h3333);
      host.pause(4);
      chk(16'(got_q.size()), 16'h0003, "edge count");
      foreach (got_q[i]) chk(got_q[i], 16'h1111 * 16'(i + 1), "edge word");
      chk(16'(dmarq), 16'h0001, "write request");
   endtask : t_wr
   // fill the fifo past full with the sink stalled, then drain
   task automatic t_fill();
      wr_ready = 1'b0;
      got_q.delete();
      for (int i = 0; i < 10; i++) host.toggle(16'hB000 + 16'(i));
      host.pause(2);
      chk(16'(overrun), 16'h0001, "overrun set");
      wr_ready = 1'b1;
      host.pause(15);
      chk(16'(got_q.size()), 16'h0009, "drained count");
      foreach (got_q[i]) chk(got_q[i], 16'hB000 + 16'(i), "drained word");
      udma_wr_en = 1'b0;
      host.ack(1'b0, 1'b0);
      cyc(2);
      chk(16'(overrun), 16'h0000, "overrun clear");
   endtask : t_fill
   // data-in: request held until acknowledge, ready pauses the burst
   task automatic t_rd();
      udma_rd_en = 1'b1;
      src_valid = 1'b1;
      src_data = 16'h5A5A;
      cyc(3);
      chk(16'(dmarq), 16'h0001, "request held");
      chk(16'(src_ready), 16'h0000, "no ack no take");
      old_strobe = dstrobe;
      host.ack(1'b1, 1'b1);
      cyc(1);
      host.ack(1'b1, 1'b0);
      src_data = 16'h1234;
      chk(dd_out, 16'h5A5A, "din word");
      chk(16'(dd_oe), 16'h0001, "din drive");
      chk(16'(dstrobe), 16'(!old_strobe), "din strobe");
      cyc(3);
      chk(dd_out, 16'h5A5A, "paused word");
      chk(16'(dstrobe), 16'(!old_strobe), "paused strobe");
      src_valid = 1'b0;
      cyc(2);
      chk(16'(dmarq), 16'h0000, "request drop");
      udma_rd_en = 1'b0;
      host.ack(1'b0, 1'b0);
   endtask : t_rd
   task automatic conclude();
      if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////
   // reset for four cycles, then every scenario
   initial begin
      srst = 1'b1;
      mode_sel = 2'h0;
      io_if_en = 1'b0;
      udma_rd_en = 1'b0;
      udma_wr_en = 1'b0;
      src_valid = 1'b0;
      wr_ready = 1'b0;
      io_rdata = 16'h0000;
      src_data = 16'h0000;
      cyc(4);
      srst = 1'b0;
      chk(16'({dd_oe, dmarq, wr_valid, overrun}), 16'h0000, "reset outputs");
      t_pio();
      t_wr();
      t_fill();
      t_rd();
      conclude();
   end
endmodule : host_read_and_udma_strobes_tb
